// ---- pkg/rbm_pkg.sv ----
// constants and carrier types for the reset-time boot mode selector
// assumes a single core clock and a synchronous active-low reset
package rbm_pkg;

  // ----------------------------------------
  // pin levels
  // ----------------------------------------
  localparam logic PFS_DOWNLOAD = 1'b0;
  localparam logic PFS_IDLE = 1'b1;
  localparam logic EA_EXTERNAL = 1'b0;
  localparam logic OE_DRIVE_N = 1'b0;
  localparam logic OE_RELEASE_N = 1'b1;

  // ----------------------------------------
  // widths and reset values
  // ----------------------------------------
  localparam int FLASH_ADDR_W = 13;
  localparam int BYTE_W = 8;
  localparam int SYNC_DEPTH = 3;
  localparam logic [FLASH_ADDR_W-1:0] FLASH_ADDR_RST = 13'h0000;
  localparam logic [FLASH_ADDR_W-1:0] FLASH_ADDR_ONE = 13'h0001;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    BOOT_SAMPLE,
    BOOT_NORMAL,
    BOOT_DOWNLOAD
  } rbm_boot_e;

  typedef struct packed {
    logic download;
    logic runUser;
    logic extFetch;
    logic in_circuit_emulation;
  } rbm_mode_s;

  typedef struct packed {
    logic en;
    logic [FLASH_ADDR_W-1:0] addr;
    logic [BYTE_W-1:0] data;
  } rbm_flash_wr_s;

endpackage

// ---- src/rbm_boot_select.sv ----
// reset-time boot mode selector: strap sampling, mode latch, loader and debug gating
// assumes strap pins arrive asynchronously and the uart byte stream is on clk
`timescale 1ns/100ps
module rbm_boot_select import rbm_pkg::*; #(
  parameter int ADDR_W = FLASH_ADDR_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fetch strobe pin, two-way
  input wire logic pfsIn,
  output logic pfsOut,
  output logic pfsOe_n,
  // external access pin
  input wire logic eaIn,
  // core side
  input wire logic coreFetch_n,
  input wire logic [ADDR_W-1:0] pcIn,
  output logic coreHalt,
  output logic coreStep,
  output rbm_mode_s mode,
  // uart byte stream and flash write port
  input wire logic rxValid,
  input wire logic [BYTE_W-1:0] rxData,
  output rbm_flash_wr_s flashWr,
  // debug commands
  input wire logic dbgRun,
  input wire logic dbgHalt,
  input wire logic dbgStep,
  input wire logic bkptEn,
  input wire logic [ADDR_W-1:0] bkptAddr
);

  if (ADDR_W < 1 || ADDR_W > FLASH_ADDR_W) begin : g_chk
    $error("ADDR_W out of range");
  end

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [SYNC_DEPTH-1:0] pfsSh_r, pfsSh_nxt, eaSh_r, eaSh_nxt;
  logic pfsStable_r, pfsStable_nxt, eaStable_r, eaStable_nxt;

  // a level counts only once the last two stages agree
  always_comb begin
    pfsSh_nxt = {pfsSh_r[SYNC_DEPTH-2:0], pfsIn};
    eaSh_nxt = {eaSh_r[SYNC_DEPTH-2:0], eaIn};
    pfsStable_nxt = pfsStable_r;
    eaStable_nxt = eaStable_r;
    if (pfsSh_r[SYNC_DEPTH-2] == pfsSh_r[SYNC_DEPTH-1]) begin
      pfsStable_nxt = pfsSh_r[SYNC_DEPTH-1];
    end
    if (eaSh_r[SYNC_DEPTH-2] == eaSh_r[SYNC_DEPTH-1]) begin
      eaStable_nxt = eaSh_r[SYNC_DEPTH-1];
    end
  end

  // free running so the strap is settled by the time reset releases
  always_ff @(posedge clk) begin
    pfsSh_r <= pfsSh_nxt;
    eaSh_r <= eaSh_nxt;
    pfsStable_r <= pfsStable_nxt;
    eaStable_r <= eaStable_nxt;
  end

  // ----------------------------------------
  // boot mode and outputs
  // ----------------------------------------
  rbm_boot_e state_r, state_nxt;
  rbm_mode_s mode_r, mode_nxt;
  rbm_flash_wr_s flashWr_r, flashWr_nxt;
  logic [FLASH_ADDR_W-1:0] wrAddr_r, wrAddr_nxt;
  logic halt_r, halt_nxt, step_r, step_nxt;
  logic pfsOut_r, pfsOut_nxt, pfsOe_n_r, pfsOe_n_nxt;
  logic [FLASH_ADDR_W-1:0] pcExt, bkExt;

  assign pcExt = FLASH_ADDR_W'(pcIn);
  assign bkExt = FLASH_ADDR_W'(bkptAddr);

  always_comb begin
    state_nxt = state_r;
    mode_nxt = mode_r;
    flashWr_nxt = '0;
    wrAddr_nxt = wrAddr_r;
    halt_nxt = halt_r;
    step_nxt = 1'b0;
    pfsOut_nxt = coreFetch_n;
    pfsOe_n_nxt = OE_DRIVE_N;
    case (state_r)
      BOOT_SAMPLE: begin
        // single input sample of the strobe pin
        pfsOut_nxt = PFS_IDLE;
        if (pfsStable_r == PFS_DOWNLOAD) begin
          state_nxt = BOOT_DOWNLOAD;
          mode_nxt.download = 1'b1;
        end else begin
          state_nxt = BOOT_NORMAL;
          mode_nxt.runUser = 1'b1;
          halt_nxt = 1'b0;
        end
        mode_nxt.extFetch = (eaStable_r == EA_EXTERNAL);
      end
      BOOT_NORMAL: begin
        halt_nxt = 1'b0;
      end
      BOOT_DOWNLOAD: begin
        if (rxValid) begin
          flashWr_nxt.en = 1'b1;
          flashWr_nxt.addr = wrAddr_r;
          flashWr_nxt.data = rxData;
          wrAddr_nxt = wrAddr_r + FLASH_ADDR_ONE;
        end
        // debug control of the core
        if (halt_r) begin
          if (dbgRun) begin
            halt_nxt = 1'b0;
          end else if (dbgStep) begin
            step_nxt = 1'b1;
          end
        end else if (dbgHalt || (bkptEn && pcExt == bkExt)) begin
          halt_nxt = 1'b1;
        end
      end
      default: begin
        state_nxt = BOOT_SAMPLE;
      end
    endcase
    // weak pull high at reset then driven low means an emulator is attached
    if (state_r != BOOT_SAMPLE && !mode_r.extFetch && eaStable_r == EA_EXTERNAL) begin
      mode_nxt.in_circuit_emulation = 1'b1;
    end
  end

  // mode stays fixed until the next reset, except in_circuit_emulation which can still set
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= BOOT_SAMPLE;
      mode_r <= '0;
      flashWr_r <= '0;
      wrAddr_r <= FLASH_ADDR_RST;
      halt_r <= 1'b1;
      step_r <= 1'b0;
      pfsOut_r <= PFS_IDLE;
      pfsOe_n_r <= OE_RELEASE_N;
    end else begin
      state_r <= state_nxt;
      mode_r <= mode_nxt;
      flashWr_r <= flashWr_nxt;
      wrAddr_r <= wrAddr_nxt;
      halt_r <= halt_nxt;
      step_r <= step_nxt;
      pfsOut_r <= pfsOut_nxt;
      pfsOe_n_r <= pfsOe_n_nxt;
    end
  end

  assign pfsOut = pfsOut_r;
  assign pfsOe_n = pfsOe_n_r;
  assign mode = mode_r;
  assign flashWr = flashWr_r;
  assign coreHalt = halt_r;
  assign coreStep = step_r;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_strap_download: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == BOOT_SAMPLE && pfsStable_r == PFS_DOWNLOAD |=> mode_r.download && !mode_r.runUser)
    else $error("low strap did not select download");

  a_strap_normal: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == BOOT_SAMPLE && pfsStable_r != PFS_DOWNLOAD |=> mode_r.runUser && !coreHalt)
    else $error("high strap did not start user program");

  a_pin_output: assert property (@(posedge clk) disable iff (!rst_n)
    state_r != BOOT_SAMPLE |-> pfsOe_n == OE_DRIVE_N
      && pfsOut == (($past(state_r) == BOOT_SAMPLE) ? PFS_IDLE : $past(coreFetch_n)))
    else $error("strobe pin not driven after sample");

  a_mode_held: assert property (@(posedge clk) disable iff (!rst_n)
    state_r != BOOT_SAMPLE |=> $stable(state_r) && $stable(mode_r.download))
    else $error("boot mode changed before reset");

  a_one_mode: assert property (@(posedge clk) disable iff (!rst_n)
    !(mode_r.download && mode_r.runUser))
    else $error("download and normal both set");

  a_flash_write: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == BOOT_DOWNLOAD && rxValid |=> flashWr.en && flashWr.data == $past(rxData)
      && wrAddr_r == flashWr.addr + FLASH_ADDR_ONE)
    else $error("received byte not written to flash");

  a_no_write_normal: assert property (@(posedge clk) disable iff (!rst_n)
    state_r != BOOT_DOWNLOAD |=> !flashWr.en)
    else $error("flash written outside download mode");

  a_bkpt_halt: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == BOOT_DOWNLOAD && !coreHalt && bkptEn && pcExt == bkExt |=> coreHalt)
    else $error("breakpoint did not halt core");

  a_step_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    coreStep |-> $past(coreHalt) && $past(dbgStep) && !$past(dbgRun))
    else $error("step pulse malformed");

  a_ea_select: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == BOOT_SAMPLE |=> mode_r.extFetch == ($past(eaStable_r) == EA_EXTERNAL))
    else $error("fetch source does not follow access pin");

  a_ice_latch: assert property (@(posedge clk) disable iff (!rst_n)
    mode_r.in_circuit_emulation |=> mode_r.in_circuit_emulation && !mode_r.extFetch)
    else $error("emulation flag dropped");

endmodule

// ---- dv/rbm_host_model.sv ----
// host side: strap jumper on the strobe pin, uart byte source, debug commands
// assumes the bench calls its tasks at a falling clock edge
`timescale 1ns/100ps
module rbm_host_model import rbm_pkg::*; (
  // clock
  input wire logic clk,
  // strobe pin
  input wire logic pfsOut,
  input wire logic pfsOe_n,
  output logic pfsIn,
  // uart and debug
  output logic rxValid,
  output logic [BYTE_W-1:0] rxData,
  output logic dbgRun,
  output logic dbgHalt,
  output logic dbgStep
);
  logic jumperOn = 1'b0;
  // jumper pulls low only while the pin is released, else the driven pfsOut wins; no jumper gives the idle pull
  assign pfsIn = (pfsOe_n === OE_DRIVE_N) ? pfsOut : (jumperOn ? PFS_DOWNLOAD : PFS_IDLE);
  initial begin
    rxValid = 1'b0;
    rxData = 8'h00;
    {dbgRun, dbgHalt, dbgStep} = 3'h0;
  end
  task automatic putByte(input logic [BYTE_W-1:0] d);
    rxValid = 1'b1;
    rxData = d;
    @(negedge clk);
  endtask
  // released data shows no stale byte
  task automatic idle();
    rxValid = 1'b0;
    rxData = ~rxData;
  endtask
  task automatic cmd(input int k);
    {dbgRun, dbgHalt, dbgStep} = {k == 0, k == 1, k == 2};
    @(negedge clk);
    {dbgRun, dbgHalt, dbgStep} = 3'h0;
  endtask
endmodule

// ---- dv/testbench.sv ----
// self-checking bench for the boot mode selector
// assumes the host model resolves the strobe pin and sources uart and debug traffic
`timescale 1ns/100ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module testbench import rbm_pkg::*;;
  logic clk = 1'b0, rst_n = 1'b0, eaIn = 1'b1, coreFetch_n = 1'b1, bkptEn = 1'b0;
  logic pfsIn, pfsOut, pfsOe_n, coreHalt, coreStep, rxValid, dbgRun, dbgHalt, dbgStep;
  logic [FLASH_ADDR_W-1:0] pcIn = 13'h0000, bkptAddr = 13'h1FFF;
  logic [BYTE_W-1:0] rxData;
  rbm_mode_s mode;
  rbm_flash_wr_s flashWr;
  int miscompares = 0, total_checks = 0, cycles = 0;
  rbm_host_model host (.clk(clk), .pfsOut(pfsOut), .pfsOe_n(pfsOe_n), .pfsIn(pfsIn),
    .rxValid(rxValid), .rxData(rxData), .dbgRun(dbgRun), .dbgHalt(dbgHalt), .dbgStep(dbgStep));
  rbm_boot_select i_dut (.clk(clk), .rst_n(rst_n), .pfsIn(pfsIn), .pfsOut(pfsOut),
    .pfsOe_n(pfsOe_n), .eaIn(eaIn), .coreFetch_n(coreFetch_n), .pcIn(pcIn),
    .coreHalt(coreHalt), .coreStep(coreStep), .mode(mode), .rxValid(rxValid),
    .rxData(rxData), .flashWr(flashWr), .dbgRun(dbgRun), .dbgHalt(dbgHalt),
    .dbgStep(dbgStep), .bkptEn(bkptEn), .bkptAddr(bkptAddr));
  initial forever #2 clk = ~clk;
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      print_verdict();
    end
  end
  task automatic bootWith(input logic jump, input logic ea);
    rst_n = 1'b0;
    host.jumperOn = jump;
    eaIn = ea;
    repeat (16) @(negedge clk);
    `CHK("oe in reset", OE_RELEASE_N, pfsOe_n)
    rst_n = 1'b1;
    @(negedge clk);
    `CHK("oe after sample", OE_DRIVE_N, pfsOe_n)
    @(negedge clk);
  endtask
  task automatic testNormal();
    bootWith(1'b0, 1'b1);
    `CHK("runUser", 1'b1, mode.runUser)
    `CHK("download", 1'b0, mode.download)
    `CHK("extFetch", 1'b0, mode.extFetch)
    `CHK("oe driven", OE_DRIVE_N, pfsOe_n)
    `CHK("halt", 1'b0, coreHalt)
    coreFetch_n = 1'b0;
    @(negedge clk);
    `CHK("pfsOut", 1'b0, pfsOut)
    coreFetch_n = 1'b1;
    host.putByte(8'h3C);
    `CHK("no write", 1'b0, flashWr.en)
    host.idle();
    host.cmd(1);
    `CHK("halt ignored", 1'b0, coreHalt)
    eaIn = 1'b0;
    for (int i = 0; i < 8 && mode.in_circuit_emulation !== 1'b1; i++) @(negedge clk);
    `CHK("ice", 1'b1, mode.in_circuit_emulation)
    `CHK("extFetch held", 1'b0, mode.extFetch)
    $display("test normal done");
  endtask
  task automatic testExt();
    bootWith(1'b0, 1'b0);
    `CHK("extFetch", 1'b1, mode.extFetch)
    `CHK("runUser ext", 1'b1, mode.runUser)
    $display("test external done");
  endtask
  task automatic testDownload();
    bootWith(1'b1, 1'b1);
    `CHK("download", 1'b1, mode.download)
    `CHK("runUser", 1'b0, mode.runUser)
    `CHK("halt start", 1'b1, coreHalt)
    host.jumperOn = 1'b0;
    repeat (6) @(negedge clk);
    `CHK("download kept", 1'b1, mode.download)
    host.putByte(8'h5A);
    `CHK("wr0 en", 1'b1, flashWr.en)
    `CHK("wr0 addr", 13'h0000, flashWr.addr)
    `CHK("wr0 data", 8'h5A, flashWr.data)
    host.putByte(8'hC3);
    `CHK("wr1 addr", 13'h0001, flashWr.addr)
    `CHK("wr1 data", 8'hC3, flashWr.data)
    host.idle();
    host.cmd(2);
    `CHK("step", 1'b1, coreStep)
    @(negedge clk);
    `CHK("step end", 1'b0, coreStep)
    host.cmd(0);
    `CHK("run", 1'b0, coreHalt)
    pcIn = 13'h0010;
    bkptAddr = 13'h0010;
    bkptEn = 1'b1;
    @(negedge clk);
    `CHK("bkpt halt", 1'b1, coreHalt)
    bkptEn = 1'b0;
    host.cmd(0);
    `CHK("run again", 1'b0, coreHalt)
    @(negedge clk);
    host.cmd(2);
    `CHK("step refused", 1'b0, coreStep)
    `CHK("still running", 1'b0, coreHalt)
    @(negedge clk);
    host.cmd(1);
    `CHK("cmd halt", 1'b1, coreHalt)
    $display("test download done");
  endtask
  initial begin
    @(negedge clk);
    testNormal();
    testExt();
    testDownload();
    print_verdict();
  end
endmodule
